// >>> rtl/icd_regs.vh
// Purpose: constants for the clear/call/decrement execution subset
// Assumes: 14-bit instruction words, 8-bit data, 15-bit program counter
// Notes: opcode patterns follow the usual mid-range 14-bit encoding
`ifndef ICD_REGS_VH
`define ICD_REGS_VH

// ----------------------------------------------------------------
// Opcode patterns (14-bit instruction word)
// ----------------------------------------------------------------
`define ICD_OP_DOG_CLEAR 14'h0064
`define ICD_OP_IND_CALL 14'h000A
`define ICD_OP_ZERO_ACC 14'h0100
`define ICD_GRP_ZERO_FILE 7'h03
`define ICD_GRP_INVERT 6'h09
`define ICD_GRP_MINUS_ONE 6'h03
`define ICD_GRP_SKIP 6'h0B
`define ICD_GRP_ZERO_ACC 7'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ICD_IR_MSB 13
`define ICD_DEST_BIT 7
`define ICD_FADDR_MSB 6
`define ICD_GRP6_LSB 8
`define ICD_GRP7_LSB 7
`define ICD_PCH_MSB 6

// ----------------------------------------------------------------
// Values and reset states
// ----------------------------------------------------------------
`define ICD_BYTE_ZERO 8'h00
`define ICD_BYTE_ONE 8'h01
`define ICD_PC_ONE 15'h0001
`define ICD_PC_RESET 15'h0000
`define ICD_FADDR_RESET 7'h00
`define ICD_DEST_ACC 1'b0
`define ICD_DEST_FILE 1'b1

`endif

// >>> rtl/icd_op_decode.v
// Purpose: classify one instruction word into the handled operations
// Assumes: word is stable while ir_valid_in is high
// Notes: pure combinational; anything else gives no hit
`timescale 1ns/10ps
`include "icd_regs.vh"

module icd_op_decode (
    input wire [13:0] ir_in,
    output wire dog_clear_op_out,
    output wire indirect_call_op_out,
    output wire zero_acc_op_out,
    output wire zero_file_op_out,
    output wire invert_file_op_out,
    output wire file_minus_one_op_out,
    output wire count_down_skip_op_out
);

    // ------------------------------------------------------------
    // Whole-word and group-field matches
    // ------------------------------------------------------------
    assign dog_clear_op_out = (ir_in == `ICD_OP_DOG_CLEAR);
    assign indirect_call_op_out = (ir_in == `ICD_OP_IND_CALL);
    // Low seven bits are ignored, as any of them is a legal zero_acc
    assign zero_acc_op_out = (ir_in[`ICD_IR_MSB:`ICD_GRP7_LSB] ==
        `ICD_GRP_ZERO_ACC);
    assign zero_file_op_out = (ir_in[`ICD_IR_MSB:`ICD_GRP7_LSB] ==
        `ICD_GRP_ZERO_FILE);
    assign invert_file_op_out = (ir_in[`ICD_IR_MSB:`ICD_GRP6_LSB] ==
        `ICD_GRP_INVERT);
    assign file_minus_one_op_out = (ir_in[`ICD_IR_MSB:`ICD_GRP6_LSB] ==
        `ICD_GRP_MINUS_ONE);
    assign count_down_skip_op_out = (ir_in[`ICD_IR_MSB:`ICD_GRP6_LSB] ==
        `ICD_GRP_SKIP);

endmodule // icd_op_decode

// >>> rtl/icd_exec.v
// Purpose: execute clear, indirect call, invert and decrement ops
// Assumes: one instruction word per valid cycle from the fetch stage;
//          the core supplies file data read at the word's address,
//          and pc_in is the address of that same word
// Notes: all results are registered one cycle after the word is taken.
//        A word is taken on the rising edge with ir_valid_in high and
//        busy_out low; strobes then stand for exactly one cycle, and
//        data outputs other than file_addr_out hold until the next write of the same field.
//        After an indirect call, or a skip whose result is zero, the
//        fetch stage must drop the next word (flush_out), and this
//        block ignores whatever word is offered while busy_out is high.
//        Flag results are handed back with write strobes; the status
//        bits themselves live in the core, not here.
//        Words outside the handled set leave every strobe low, so the
//        rest of the core may decode them in parallel without clashing.
`timescale 1ns/10ps
`include "icd_regs.vh"

module icd_exec (
    input wire clk_in,
    input wire resetn_in,
    input wire ir_valid_in,
    input wire [13:0] ir_in,
    input wire [14:0] pc_in,
    input wire [7:0] acc_in,
    input wire [7:0] file_data_in,
    input wire [7:0] pc_high_latch_in,
    output reg busy_out,
    output reg acc_we_out,
    output reg [7:0] acc_data_out,
    output reg file_we_out,
    output reg [6:0] file_addr_out,
    output reg [7:0] file_data_out,
    output reg zero_we_out,
    output reg zero_flag_out,
    output reg status_we_out,
    output reg timeout_flag_out,
    output reg powerdown_flag_out,
    output reg watchdog_clear_out,
    output reg prescaler_clear_out,
    output reg stack_push_out,
    output reg [14:0] stack_top_out,
    output reg pc_load_out,
    output reg [14:0] pc_out,
    output reg flush_out
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // One hit line per handled operation; at most one is ever high
    wire op_dog;
    wire op_call;
    wire op_zacc;
    wire op_zfile;
    wire op_inv;
    wire op_dec;
    wire op_skip;

    icd_op_decode icd_op_decode_inst (
        .ir_in(ir_in),
        .dog_clear_op_out(op_dog),
        .indirect_call_op_out(op_call),
        .zero_acc_op_out(op_zacc),
        .zero_file_op_out(op_zfile),
        .invert_file_op_out(op_inv),
        .file_minus_one_op_out(op_dec),
        .count_down_skip_op_out(op_skip)
    );

    // Zero test shared by the invert, decrement and skip paths (the clears
    // set the flag directly), so those three paths cannot drift apart
    function is_zero;
        input [7:0] val;
        begin
            is_zero = (val == `ICD_BYTE_ZERO);
        end
    endfunction

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    wire take;
    wire dest;
    wire [6:0] faddr;
    wire [7:0] inv_res;
    wire [7:0] dec_res;
    wire [14:0] ret_addr;
    wire [14:0] call_target;

    // Second cycle of a two-cycle op ignores the word on the bus
    assign take = ir_valid_in && !busy_out;

    // Operand fields of the file-register forms
    assign dest = ir_in[`ICD_DEST_BIT];
    assign faddr = ir_in[`ICD_FADDR_MSB:0];

    // Both results are formed every cycle; the decode picks one.
    // Decrement wraps modulo 256, so zero minus one gives all ones
    assign inv_res = ~file_data_in;
    assign dec_res = file_data_in - `ICD_BYTE_ONE;

    // Return address and call target; bit 7 of the latch is dropped,
    // as the program counter is only fifteen bits wide
    assign ret_addr = pc_in + `ICD_PC_ONE;
    assign call_target = {pc_high_latch_in[`ICD_PCH_MSB:0], acc_in};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Values that the output registers take at the next edge
    reg next_busy;
    reg next_acc_we;
    reg [7:0] next_acc_data;
    reg next_file_we;
    reg [7:0] next_file_data;
    reg next_zero_we;
    reg next_zero;
    reg next_status_we;
    reg next_dog;
    reg next_push;
    reg next_pc_load;
    reg next_flush;
    // Shared result of the three read-modify-write operations
    reg [7:0] result;
    reg has_result;

    // Only the operation taken this cycle raises any strobe
    always @* begin
        next_busy = 1'b0;
        next_acc_we = 1'b0;
        next_acc_data = acc_data_out;
        next_file_we = 1'b0;
        next_file_data = file_data_out;
        next_zero_we = 1'b0;
        next_zero = zero_flag_out;
        next_status_we = 1'b0;
        next_dog = 1'b0;
        next_push = 1'b0;
        next_pc_load = 1'b0;
        next_flush = 1'b0;
        result = `ICD_BYTE_ZERO;
        has_result = 1'b0;
        if (take) begin
            if (op_dog) begin
                // Flags return with the status strobe, beside the clears
                next_status_we = 1'b1;
                next_dog = 1'b1;
            end else if (op_call) begin
                // Push and load issue together; the stack sees the
                // old PC plus one before the PC moves
                next_push = 1'b1;
                next_pc_load = 1'b1;
                next_flush = 1'b1;
                next_busy = 1'b1;
            end else if (op_zacc) begin
                // Zero flag is set whatever the old accumulator held
                next_acc_we = 1'b1;
                next_acc_data = `ICD_BYTE_ZERO;
                next_zero_we = 1'b1;
                next_zero = 1'b1;
            end else if (op_zfile) begin
                // Address comes from the word; data and flag are fixed
                next_file_we = 1'b1;
                next_file_data = `ICD_BYTE_ZERO;
                next_zero_we = 1'b1;
                next_zero = 1'b1;
            end else if (op_inv) begin
                // Result is steered below by the destination bit
                result = inv_res;
                has_result = 1'b1;
                next_zero_we = 1'b1;
                next_zero = is_zero(inv_res);
            end else if (op_dec) begin
                // Same steering as invert; flag follows wrapped result
                result = dec_res;
                has_result = 1'b1;
                next_zero_we = 1'b1;
                next_zero = is_zero(dec_res);
            end else if (op_skip) begin
                // Status is left alone even when the skip is taken; the
                // dropped word costs the second cycle through busy_out
                result = dec_res;
                has_result = 1'b1; // flags untouched
                if (is_zero(dec_res)) begin
                    next_flush = 1'b1;
                    next_busy = 1'b1;
                end
            end
            if (has_result) begin
                if (dest == `ICD_DEST_FILE) begin
                    next_file_we = 1'b1;
                    next_file_data = result;
                end else begin
                    next_acc_we = 1'b1;
                    next_acc_data = result;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output registers: operation strobes
    // ------------------------------------------------------------
    // Every strobe drops back to zero in a cycle with nothing taken,
    // so each is a one-cycle pulse the core may act on directly
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            busy_out <= 1'b0;
            acc_we_out <= 1'b0;
            file_we_out <= 1'b0;
            zero_we_out <= 1'b0;
            status_we_out <= 1'b0;
            pc_load_out <= 1'b0;
            flush_out <= 1'b0;
        end else begin
            busy_out <= next_busy;
            acc_we_out <= next_acc_we;
            file_we_out <= next_file_we;
            zero_we_out <= next_zero_we;
            status_we_out <= next_status_we;
            pc_load_out <= next_pc_load;
            flush_out <= next_flush;
        end
    end

    // ------------------------------------------------------------
    // Output registers: result data
    // ------------------------------------------------------------
    // Data outputs hold between writes, so the core may sample them
    // late; the address follows every taken word, file form or not
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            acc_data_out <= `ICD_BYTE_ZERO;
            file_addr_out <= `ICD_FADDR_RESET;
            file_data_out <= `ICD_BYTE_ZERO;
            zero_flag_out <= 1'b0;
        end else begin
            acc_data_out <= next_acc_data;
            if (take) begin
                file_addr_out <= faddr;
            end
            file_data_out <= next_file_data;
            zero_flag_out <= next_zero;
        end
    end

    // ------------------------------------------------------------
    // Output registers: watchdog and status bits
    // ------------------------------------------------------------
    // Flag values for the dog clear are constant ones; the enable
    // strobe tells the core when to take them, so nothing else here
    // can disturb the timeout or power-down bits
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            timeout_flag_out <= 1'b1;
            powerdown_flag_out <= 1'b1;
            watchdog_clear_out <= 1'b0;
            prescaler_clear_out <= 1'b0;
        end else begin
            timeout_flag_out <= 1'b1;
            powerdown_flag_out <= 1'b1;
            watchdog_clear_out <= next_dog;
            prescaler_clear_out <= next_dog;
        end
    end

    // ------------------------------------------------------------
    // Output registers: return stack and program counter
    // ------------------------------------------------------------
    // Push value and target only move with their strobes, so a late
    // reader still sees the last call's return address and target
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            stack_push_out <= 1'b0;
            stack_top_out <= `ICD_PC_RESET;
            pc_out <= `ICD_PC_RESET;
        end else begin
            stack_push_out <= next_push;
            if (next_push) begin
                stack_top_out <= ret_addr;
            end
            if (next_pc_load) begin
                pc_out <= call_target;
            end
        end
    end

endmodule // icd_exec

// >>> tb/icd_exec_monitor.sv
// Purpose: assertions on the execution subset outputs
// Assumes: results land in the cycle after the taking edge
// Notes: bound to icd_exec, ports only
`timescale 1ns/10ps
module icd_exec_monitor (
    input wire clk_in,
    input wire resetn_in,
    input wire ir_valid_in,
    input wire [13:0] ir_in,
    input wire [14:0] pc_in,
    input wire [7:0] acc_in,
    input wire [7:0] file_data_in,
    input wire [7:0] pc_high_latch_in,
    input wire busy_out,
    input wire acc_we_out,
    input wire [7:0] acc_data_out,
    input wire file_we_out,
    input wire [6:0] file_addr_out,
    input wire [7:0] file_data_out,
    input wire zero_we_out,
    input wire zero_flag_out,
    input wire status_we_out,
    input wire timeout_flag_out,
    input wire powerdown_flag_out,
    input wire watchdog_clear_out,
    input wire prescaler_clear_out,
    input wire stack_push_out,
    input wire [14:0] stack_top_out,
    input wire pc_load_out,
    input wire [14:0] pc_out,
    input wire flush_out
);
// ----------------------------------------------------------------
// Taken words
// ----------------------------------------------------------------
default clocking @(posedge clk_in); endclocking
default disable iff (!resetn_in);
// Busy words are refused, so only these count as requests
wire take = ir_valid_in && !busy_out;
wire [6:0] pch_lo = pc_high_latch_in[6:0];
wire [6:0] faddr = ir_in[6:0];
sequence s_dog; take && ir_in == 14'h0064; endsequence
sequence s_call; take && ir_in == 14'h000A; endsequence
sequence s_skip_zero;
    take && ir_in[13:8] == 6'h0B && file_data_in == 8'h01;
endsequence
property p_dog; s_dog |=> watchdog_clear_out && timeout_flag_out
    && powerdown_flag_out && status_we_out; endproperty
a_dog: assert property (p_dog) else $error("dog clear wrong");
property p_presc; s_dog |=> prescaler_clear_out; endproperty
a_presc: assert property (p_presc) else $error("prescaler");
property p_push; s_call |=> stack_push_out
    && stack_top_out == $past(pc_in) + 15'h0001; endproperty
a_push: assert property (p_push) else $error("bad push");
property p_target; s_call |=> pc_load_out
    && pc_out == {$past(pch_lo), $past(acc_in)}; endproperty
a_target: assert property (p_target) else $error("bad target");
property p_call2; s_call |=> busy_out && !zero_we_out ##1 !busy_out;
endproperty
a_call2: assert property (p_call2) else $error("call timing");
property p_zfile; take && ir_in[13:7] == 7'h03 |=> file_we_out
    && file_data_out == 8'h00 && zero_we_out && zero_flag_out
    && file_addr_out == $past(faddr); endproperty
a_zfile: assert property (p_zfile) else $error("file clr");
property p_zacc; take && ir_in[13:7] == 7'h02 |=> acc_we_out
    && acc_data_out == 8'h00 && zero_we_out && zero_flag_out; endproperty
a_zacc: assert property (p_zacc) else $error("acc clear");
property p_inv; take && ir_in[13:7] == 7'h12 |=> acc_we_out && !file_we_out
    && acc_data_out == ~$past(file_data_in)
    && zero_flag_out == (acc_data_out == 8'h00); endproperty
a_inv: assert property (p_inv) else $error("invert");
property p_dec; take && ir_in[13:7] == 7'h07 |=> file_we_out && zero_we_out
    && file_data_out == $past(file_data_in) - 8'h01; endproperty
a_dec: assert property (p_dec) else $error("decrement");
property p_skip; s_skip_zero |=> flush_out && busy_out && !zero_we_out;
endproperty
a_skip: assert property (p_skip) else $error("skip");
endmodule // icd_exec_monitor

bind icd_exec icd_exec_monitor icd_exec_monitor_inst (.clk_in, .resetn_in,
    .ir_valid_in, .ir_in, .pc_in, .acc_in, .file_data_in, .pc_high_latch_in,
    .busy_out, .acc_we_out, .acc_data_out, .file_we_out, .file_addr_out,
    .file_data_out, .zero_we_out, .zero_flag_out, .status_we_out,
    .timeout_flag_out, .powerdown_flag_out, .watchdog_clear_out,
    .prescaler_clear_out, .stack_push_out, .stack_top_out, .pc_load_out,
    .pc_out, .flush_out);

// >>> tb/icd_exec_tb.sv
// Purpose: directed checks of the execution subset
// Assumes: inputs change on the falling edge
// Notes: each scenario judges its own results
`timescale 1ns/10ps
module icd_exec_tb;
reg clk_in = 1'b0;
reg resetn_in = 1'b0;
reg ir_valid_in = 1'b0;
reg [13:0] ir_in = 14'h0000;
reg [14:0] pc_in = 15'h0000;
reg [7:0] acc_in = 8'h00;
reg [7:0] file_data_in = 8'h00;
reg [7:0] pc_high_latch_in = 8'h00;
wire busy_out, acc_we_out, file_we_out, zero_we_out, zero_flag_out;
wire status_we_out, timeout_flag_out, powerdown_flag_out, flush_out;
wire watchdog_clear_out, prescaler_clear_out, stack_push_out, pc_load_out;
wire [7:0] acc_data_out, file_data_out;
wire [6:0] file_addr_out;
wire [14:0] stack_top_out, pc_out;
integer num_errors = 0;
integer checks = 0;
icd_exec icd_exec_inst (.clk_in, .resetn_in, .ir_valid_in, .ir_in, .pc_in,
    .acc_in, .file_data_in, .pc_high_latch_in, .busy_out, .acc_we_out,
    .acc_data_out, .file_we_out, .file_addr_out, .file_data_out,
    .zero_we_out, .zero_flag_out, .status_we_out, .timeout_flag_out,
    .powerdown_flag_out, .watchdog_clear_out, .prescaler_clear_out,
    .stack_push_out, .stack_top_out, .pc_load_out, .pc_out, .flush_out);
// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
task chk(input [14:0] got, input [14:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task end_sim;
    if (num_errors == 0 && checks > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
// One word taken, results read at the next falling edge
task issue(input [13:0] w, input [7:0] f);
    @(negedge clk_in);
    ir_in = w;
    file_data_in = f;
    ir_valid_in = 1'b1;
    @(negedge clk_in);
    ir_valid_in = 1'b0;
endtask
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task t_dog;
    issue(14'h0064, 8'h00);
    chk({status_we_out, watchdog_clear_out, timeout_flag_out,
        powerdown_flag_out}, 4'hF);
    chk(prescaler_clear_out, 1'b1);
endtask
// Call with a carry in PC and latch bit 7 set, then a refused word;
// a zero_acc just before leaves the zero flag high for the call
task t_call;
    pc_in = 15'h12FF;
    acc_in = 8'hA5;
    pc_high_latch_in = 8'hFF;
    @(negedge clk_in);
    ir_in = 14'h0100;
    ir_valid_in = 1'b1;
    @(negedge clk_in);
    ir_in = 14'h000A;
    @(negedge clk_in);
    ir_in = 14'h0064;
    chk({stack_push_out, stack_top_out}, {1'b1, 15'h1300});
    chk({pc_load_out, pc_out}, {1'b1, 15'h7FA5});
    chk({busy_out, flush_out, zero_we_out}, 3'h6);
    @(negedge clk_in);
    ir_valid_in = 1'b0;
    chk({watchdog_clear_out, busy_out, stack_push_out, pc_load_out,
        zero_flag_out}, 5'h01);
endtask
// Invert, decrement and skip for both destinations
task t_op(input [5:0] grp, input d, input [7:0] f);
    reg [7:0] res;
    reg [6:0] fa;
    reg sk;
    res = (grp == 6'h09) ? ~f : f - 8'h01;
    fa = ~f[6:0];
    sk = (grp == 6'h0B);
    issue({grp, d, fa}, f);
    chk({file_we_out, acc_we_out}, {d, !d});
    chk(d ? file_data_out : acc_data_out, res);
    chk(file_addr_out, fa);
    chk(zero_we_out, !sk);
    if (!sk) chk(zero_flag_out, res == 8'h00);
    chk({flush_out, busy_out}, {2{sk && res == 8'h00}});
endtask
task t_clear;
    issue(14'h0900, 8'h00);
    issue(14'h01C3, 8'h00);
    chk({file_we_out, file_data_out, zero_flag_out}, 10'h201);
    chk(file_addr_out, 7'h43);
    issue(14'h0900, 8'h00);
    issue(14'h0100, 8'h00);
    chk({acc_we_out, acc_data_out, zero_flag_out}, 10'h201);
endtask
// ----------------------------------------------------------------
// Clock, sequence and watchdog
// ----------------------------------------------------------------
initial forever #12.5 clk_in = ~clk_in;
initial begin : main_seq
    integer g, d, k;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    t_dog;
    t_call;
    for (g = 0; g < 3; g = g + 1) begin
        for (d = 0; d < 2; d = d + 1) begin
            for (k = 0; k < 4; k = k + 1) begin
                t_op(g == 0 ? 6'h09 : g == 1 ? 6'h03 : 6'h0B, d[0],
                    k == 0 ? 8'h00 : k == 1 ? 8'h01 : k == 2 ? 8'hFF : 8'h80);
            end
        end
    end
    t_clear;
    end_sim;
end
// A hang costs a mismatch and ends the run the normal way
initial begin
    #200000;
    num_errors = num_errors + 1;
    end_sim;
end
endmodule // icd_exec_tb
